// [src/tx_phase_comp_defs.vh]
// Purpose: Constants shared by the transmit phase compensation buffer.
// Assumes: Included by bare name from the design files.
// Notes: Offsets and counts are held here once; the code uses the names.
`ifndef TX_PHASE_COMP_DEFS_VH
`define TX_PHASE_COMP_DEFS_VH

// Storage depth in words and pointer width.
`define TXPC_DEPTH 4
`define TXPC_PTR_W 2
// Fixed spacing between write and read pointers after reset.
`define TXPC_PTR_GAP 2'h2
// Pointer reset value.
`define TXPC_PTR_RST 2'h0
// Writes needed before the read side starts.
`define TXPC_PRIME_CNT 2'h2

// Configured word width codes.
`define TXPC_W8 2'h0
`define TXPC_W10 2'h1
`define TXPC_W16 2'h2
`define TXPC_W20 2'h3

// Widths that the codes select.
`define TXPC_BITS8 8
`define TXPC_BITS10 10
`define TXPC_BITS16 16
`define TXPC_BITS20 20

`endif

// [src/tx_pc_slot.v]
// Purpose: One storage word of the transmit phase compensation buffer.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Holds the data word and its valid flag.
`timescale 1ns/1ps

module tx_pc_slot #(
  parameter WIDTH = 21
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Write side
  input wire writeEn,
  input wire [WIDTH-1:0] writeData,
  // Stored word
  output reg [WIDTH-1:0] word_q
);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      word_q <= {WIDTH{1'b0}};
    end else if (writeEn) begin
      word_q <= writeData;
    end
  end

endmodule

// [src/tx_phase_comp_fifo.v]
// Purpose: Transmit phase compensation buffer between fabric words and the coding stage.
// Assumes: Both sides are frequency locked and presented on core_clk; inputs synchronous.
// Notes: A fixed pointer spacing absorbs phase offset; registered mode bypasses storage.
`timescale 1ns/1ps
`include "tx_phase_comp_defs.vh"

// Behaviour
// - Absorb phase offset between fabric write side and coding-side reads.
// - Store exactly four transmit words between write and read sides.
// - Buffered mode delivers each word after exactly three parallel cycles.
// - Registered mode passes words through one register, one cycle latency.
// - Word width is 8, 10, 16 or 20 bits, used for every transfer.
// - Accept words from fabric or from the protocol core interface alike.
// - Forward words onward to the coding stage as the first stage.
module tx_phase_comp_fifo #(
  parameter DATA_WIDTH = 20,
  parameter DEPTH = `TXPC_DEPTH
) (
  // Clock and reset
  core_clk,
  resetn,
  // Configuration
  registeredMode,
  widthSel,
  pipeSel,
  // Fabric source
  fabricData,
  fabricValid,
  // Protocol core source
  pipeData,
  pipeValid,
  // Coding stage side
  txWord_q,
  txValid_q,
  running_q
);

  input wire core_clk;
  input wire resetn;
  input wire registeredMode;
  input wire [1:0] widthSel;
  input wire pipeSel;
  input wire [DATA_WIDTH-1:0] fabricData;
  input wire fabricValid;
  input wire [DATA_WIDTH-1:0] pipeData;
  input wire pipeValid;
  output reg [DATA_WIDTH-1:0] txWord_q;
  output reg txValid_q;
  output reg running_q;

  localparam SLOT_W = DATA_WIDTH + 1;

  // Start-up sequencer states, one-hot.
  localparam [1:0] ST_PRIME = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // Masks for the four word widths; bits above the width never reach the coding stage.
  localparam [DATA_WIDTH-1:0] MASK_ALL = {DATA_WIDTH{1'b1}};
  localparam [DATA_WIDTH-1:0] MASK_W8 = MASK_ALL >> (DATA_WIDTH - `TXPC_BITS8);
  localparam [DATA_WIDTH-1:0] MASK_W10 = MASK_ALL >> (DATA_WIDTH - `TXPC_BITS10);
  localparam [DATA_WIDTH-1:0] MASK_W16 = MASK_ALL >> (DATA_WIDTH - `TXPC_BITS16);
  localparam [DATA_WIDTH-1:0] MASK_W20 = MASK_ALL >> (DATA_WIDTH - `TXPC_BITS20);

  // Source selection
  reg [DATA_WIDTH-1:0] srcData;
  reg srcValid;
  // Width handling
  reg [DATA_WIDTH-1:0] widthMask;
  wire [SLOT_W-1:0] inWord;
  // Pointers
  reg [`TXPC_PTR_W-1:0] wrPtr_q;
  reg [`TXPC_PTR_W-1:0] wrPtr_d;
  reg [`TXPC_PTR_W-1:0] rdPtr_q;
  reg [`TXPC_PTR_W-1:0] rdPtr_d;
  // Start-up sequencer
  reg [1:0] primeCnt_q;
  reg [1:0] primeCnt_d;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg running_d;
  // Storage
  wire [SLOT_W-1:0] slotWord [0:DEPTH-1];
  wire [SLOT_W-1:0] rdWord;
  // Output stage
  reg [DATA_WIDTH-1:0] txWord_d;
  reg txValid_d;

  // Both sources share the same compensation path, so a word from the protocol
  // core sees exactly the latency of a word from the fabric.
  always @* begin
    if (pipeSel) begin
      srcData = pipeData;
      srcValid = pipeValid;
    end else begin
      srcData = fabricData;
      srcValid = fabricValid;
    end
  end

  // Bits above the configured width are forced low on every transfer.
  always @* begin
    case (widthSel)
      `TXPC_W8: widthMask = MASK_W8;
      `TXPC_W10: widthMask = MASK_W10;
      `TXPC_W16: widthMask = MASK_W16;
      `TXPC_W20: widthMask = MASK_W20;
      default: widthMask = MASK_ALL;
    endcase
  end

  // The valid flag travels in the top bit of each slot.
  assign inWord = {srcValid, srcData & widthMask};

  // Four word slots, written in turn by the write pointer.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : gSlot
      localparam [`TXPC_PTR_W-1:0] SLOT_IDX = gi;
      tx_pc_slot #(
        .WIDTH(SLOT_W)
      ) uSlot (
        .core_clk(core_clk),
        .resetn(resetn),
        .writeEn(wrPtr_q == SLOT_IDX),
        .writeData(inWord),
        .word_q(slotWord[gi])
      );
    end
  endgenerate

  // The read side sees the slot that the read pointer names.
  assign rdWord = slotWord[rdPtr_q];

  // Start-up sequencer. After reset the write side runs alone for a fixed
  // number of words; only then may the read side start, so the pointers keep
  // their spacing for the rest of the run.
  always @* begin
    state_d = state_q;
    primeCnt_d = primeCnt_q;
    running_d = running_q;
    case (state_q)
      ST_PRIME: begin
        if (primeCnt_q != `TXPC_PRIME_CNT - 2'h1) begin
          primeCnt_d = primeCnt_q + 2'h1;
        end else begin
          state_d = ST_RUN;
          running_d = 1'b1;
        end
      end
      ST_RUN: begin
        running_d = 1'b1;
      end
      default: begin
        state_d = ST_PRIME;
        primeCnt_d = 2'h0;
        running_d = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      primeCnt_q <= 2'h0;
      state_q <= ST_PRIME;
      running_q <= 1'b0;
    end else begin
      primeCnt_q <= primeCnt_d;
      state_q <= state_d;
      running_q <= running_d;
    end
  end

  // The write pointer advances on every edge, since a word arrives each cycle.
  // While priming, the read pointer is pinned a fixed gap behind the write
  // pointer; once running it simply follows, and as both sides are locked the
  // gap never drifts, whatever their phase.
  always @* begin
    wrPtr_d = wrPtr_q + 2'h1;
    if (running_q) begin
      rdPtr_d = rdPtr_q + 2'h1;
    end else begin
      rdPtr_d = wrPtr_d - `TXPC_PTR_GAP;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= `TXPC_PTR_RST;
      rdPtr_q <= `TXPC_PTR_RST;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
    end
  end

  // Output stage to the coding logic, the first stage on the way out.
  // Registered mode takes the selected word straight into the output register,
  // trading phase tolerance for a latency of exactly one cycle.
  always @* begin
    txWord_d = {DATA_WIDTH{1'b0}};
    txValid_d = 1'b0;
    if (registeredMode) begin
      txWord_d = inWord[DATA_WIDTH-1:0];
      txValid_d = inWord[DATA_WIDTH];
    end else if (running_q) begin
      txWord_d = rdWord[DATA_WIDTH-1:0];
      txValid_d = rdWord[DATA_WIDTH];
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txWord_q <= {DATA_WIDTH{1'b0}};
      txValid_q <= 1'b0;
    end else begin
      txWord_q <= txWord_d;
      txValid_q <= txValid_d;
    end
  end

endmodule

// [verification/word_src.sv]
// Purpose: Word source for the fabric or core side. Assumes: Steps at the falling edge. Notes: A new word each cycle.
`timescale 1ns/1ps
module word_src #(parameter logic [19:0] SEED = 20'h0) (
  input wire core_clk,
  output logic [19:0] data = 20'h0,
  output logic valid = 1'b0);
  logic [19:0] cnt = 20'h0;
  // All 20 bits carry data at every width, so a missed mask shows up.
  always @(negedge core_clk) begin
    cnt <= cnt + 20'h1;
    data <= SEED ^ (cnt * 20'h9E37);
    valid <= cnt[0] ^ cnt[2];
  end
endmodule

// [verification/tx_pc_chk.sv]
// Purpose: Port checks of the phase buffer. Assumes: Config static between resets. Notes: Bound below.
`timescale 1ns/1ps
module tx_pc_chk #(parameter DATA_WIDTH = 20) (
  input wire core_clk, resetn, registeredMode, pipeSel, fabricValid, pipeValid, txValid_q, running_q,
  input wire [1:0] widthSel,
  input wire [DATA_WIDTH-1:0] fabricData, pipeData, txWord_q);
  wire [19:0] k = widthSel[1] ? (widthSel[0] ? 20'hFFFFF : 20'hFFFF) : (widthSel[0] ? 20'h3FF : 20'hFF);
  wire [19:0] d = (pipeSel ? pipeData : fabricData) & k;
  wire v = pipeSel ? pipeValid : fabricValid;
  wire b = !registeredMode;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence prime_s; !running_q ##1 !running_q ##1 running_q; endsequence
  start_gap_a: assert property ($rose(resetn) |-> prime_s) else $error("start");
  run_hold_a: assert property (running_q |=> running_q) else $error("hold");
  idle_zero_a: assert property (!running_q && b |-> !txValid_q && txWord_q == 0) else $error("idle");
  buf_data_a: assert property (b && $past(running_q) |-> txWord_q == $past(d, 3)) else $error("bdata");
  buf_valid_a: assert property (b && $past(running_q) |-> txValid_q == $past(v, 3)) else $error("bval");
  reg_data_a: assert property (!b && $past(resetn) |-> txWord_q == $past(d)) else $error("rdata");
  reg_valid_a: assert property (!b && $past(resetn) |-> txValid_q == $past(v)) else $error("rval");
  word_mask_a: assert property ((txWord_q & ~k) == 0) else $error("mask");
endmodule
bind tx_phase_comp_fifo tx_pc_chk #(.DATA_WIDTH(DATA_WIDTH)) i_chk (.core_clk, .resetn, .registeredMode, .pipeSel,
  .fabricValid, .pipeValid, .txValid_q, .running_q, .widthSel, .fabricData, .pipeData, .txWord_q);

// [verification/tx_phase_comp_fifo_tb.sv]
// Purpose: Bench of the phase buffer. Assumes: Fresh reset per case. Notes: Expected words queued on entry.
`timescale 1ns/1ps
module tx_phase_comp_fifo_tb;
  logic core_clk = 1'b0, resetn = 1'b0, registeredMode = 1'b0, pipeSel = 1'b0;
  logic [1:0] widthSel = 2'h0;
  wire [19:0] fabricData, pipeData, txWord_q;
  wire fabricValid, pipeValid, txValid_q, running_q;
  int errorCnt = 0, totalChecks = 0;
  always #5 core_clk = ~core_clk;
  word_src #(.SEED(20'h5A3C1)) i_fab (.core_clk, .data(fabricData), .valid(fabricValid));
  word_src #(.SEED(20'hA5C3E)) i_core (.core_clk, .data(pipeData), .valid(pipeValid));
  tx_phase_comp_fifo i_dut (.core_clk, .resetn, .registeredMode, .widthSel, .pipeSel, .fabricData, .fabricValid,
    .pipeData, .pipeValid, .txWord_q, .txValid_q, .running_q);
  task cmp(input logic [20:0] got, input logic [20:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task completeRun;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // While the pointers prime the buffered outputs stay at zero; then each word trails by two cycles.
  task automatic run(input logic m, s, input logic [1:0] w);
    logic [20:0] q[$];
    logic [19:0] k;
    k = w[1] ? (w[0] ? 20'hFFFFF : 20'hFFFF) : (w[0] ? 20'h3FF : 20'hFF);
    {resetn, registeredMode, pipeSel, widthSel} = {1'b0, m, s, w};
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      q.push_back(s ? {pipeValid, pipeData & k} : {fabricValid, fabricData & k});
      @(negedge core_clk);
      if (i < 2) cmp(21'(running_q), 21'(i));
      if (m) cmp({txValid_q, txWord_q}, q[i]);
      else cmp({txValid_q, txWord_q}, i < 2 ? 21'h0 : q[i - 2]);
    end
  endtask
  task test_widths;
    for (int w = 0; w < 4; w++) run(1'b0, 1'b0, w[1:0]);
    $display("widths done");
  endtask
  task test_core;
    run(1'b0, 1'b1, 2'h3);
    $display("core source done");
  endtask
  task test_registered;
    run(1'b1, 1'b0, 2'h2);
    run(1'b1, 1'b1, 2'h1);
    $display("registered done");
  endtask
  initial begin
    test_widths();
    test_core();
    test_registered();
    completeRun();
  end
  // About 200 cycles are needed; the limit leaves ample slack.
  initial begin
    #8000;
    errorCnt++;
    completeRun();
  end
endmodule
